// [hw/aso_map.svh]
`ifndef ASO_MAP_SVH
`define ASO_MAP_SVH
`define ASO_PIPE_LAT 5'd12
`define ASO_SER_LAT_1W 5'd0
`define ASO_SER_LAT_LONG 5'd2
`define ASO_SER_LAT_SHORT 5'd1
`define ASO_SER_LAT_OTHER 5'd0
`define ASO_FIFO_DEPTH 32
`define ASO_TOGGLE_A 14'h2AAA
`define ASO_TOGGLE_B 14'h1555
`define ASO_ALL_ONES 14'h3FFF
`define ASO_G166 16'h1788
`define ASO_G200 16'h1388
`define ASO_G250 16'h0FA0
`define ASO_G333 16'h0BBB
`define ASO_G500 16'h07D0
`endif

// [hw/aso_pkg.sv]
`default_nettype none
package aso_pkg;
    typedef enum logic [2:0] {
        ASO_PAT_NONE = 3'h0, ASO_PAT_ZEROS = 3'h1, ASO_PAT_ONES = 3'h2,
        ASO_PAT_TOGGLE = 3'h3, ASO_PAT_CUSTOM = 3'h4, ASO_PAT_SYNC = 3'h5,
        ASO_PAT_DESKEW = 3'h6
    } aso_pat_t;
    typedef enum logic [1:0] {ASO_HS_IDLE = 2'b01, ASO_HS_BUSY = 2'b10} aso_hs_t;
    typedef struct packed {
        logic twoWire;
        logic ser16;
        logic bitWise;
        logic lsbFirst;
        logic sync;
        logic deskew;
    } aso_cfg_t;
    typedef struct packed {
        aso_cfg_t cfg;
        logic [3:0][13:0] data;
    } aso_word_t;
endpackage : aso_pkg
`default_nettype wire

// [hw/aso_word_if.sv]
`default_nettype none
interface aso_word_if;
    import aso_pkg::*;
    aso_word_t word;
    logic req;
    logic ack;
    modport src(output word, output req, input ack);
    modport snk(input word, input req, output ack);
endinterface : aso_word_if
`default_nettype wire

// [hw/aso_fifo.sv]
`default_nettype none
module aso_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // fill side
    input wire logic inValid,
    input wire logic [W-1:0] inData,
    output logic inReady,
    // drain side
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } aso_fifo_st_t;
    aso_fifo_st_t r, n;
    logic push, pop;

    // flags straight from the count, so full and empty are exact
    assign inReady = (r.cnt != (AW+1)'(D));
    assign outValid = (r.cnt != '0);
    assign outData = r.mem[r.rp];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // pointer and count update
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = inData;
            n.wp = r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = r.rp + 1'b1;
        end
        if (push && !pop) begin
            n.cnt = r.cnt + 1'b1;
        end else if (pop && !push) begin
            n.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rstN)
        r.cnt <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule : aso_fifo
`default_nettype wire

// [hw/aso_ser.sv]
`include "aso_map.svh"
`default_nettype none
module aso_ser
    import aso_pkg::*;
(
    // link clock and reset
    input wire logic linkClk,
    input wire logic linkRstN,
    // words from the system side
    aso_word_if.snk w,
    // serial pins
    output logic [7:0] serData,
    output logic frameClkOut,
    output logic bitClockOut
);
    typedef struct packed {
        logic reqS1;
        logic reqS2;
        logic seen;
        aso_word_t hold;
        aso_cfg_t cur;
        logic [7:0][15:0] sh;
        logic [4:0] cnt;
        logic half;
        logic frame;
        logic bclk;
        logic [7:0] dout;
    } aso_ser_st_t;
    aso_ser_st_t r, n;
    logic load;

    // bits per wire per sample
    function automatic logic [4:0] nBits(aso_cfg_t c);
        if (c.twoWire) begin
            nBits = c.ser16 ? 5'd8 : 5'd7;
        end else begin
            nBits = c.ser16 ? 5'd16 : 5'd14;
        end
    endfunction : nBits

    // one wire's bits, first bit to send in bit 15
    function automatic logic [15:0] laneBits(aso_cfg_t c, logic [13:0] d, logic hi);
        logic [15:0] full;
        logic [15:0] v;
        logic [15:0] o;
        int nb;
        full = {2'b00, d};
        v = '0;
        o = '0;
        nb = int'(nBits(c));
        for (int i = 0; i < 16; i++) begin
            if (i < nb) begin
                if (!c.twoWire) begin
                    v[i] = hi ? 1'b0 : full[i];
                end else if (c.bitWise) begin
                    v[i] = full[2*i + int'(hi)];
                end else begin
                    v[i] = full[i + (hi ? nb : 0)];
                end
                if (c.sync && (c.twoWire || !hi)) begin
                    v[i] = (i >= nb / 2);
                end
            end
        end
        for (int i = 0; i < 16; i++) begin
            if (i < nb) begin
                o[15-i] = c.lsbFirst ? v[i] : v[nb-1-i];
                if (c.deskew) begin
                    o[15-i] = (i % 2 == 0);
                end
            end
        end
        laneBits = o;
    endfunction : laneBits

    assign w.ack = r.seen;
    assign serData = r.dout;
    assign frameClkOut = r.frame;
    assign bitClockOut = r.bclk;
    assign load = !r.half && (r.cnt == 5'd0);

    // two link cycles per bit: data moves on one, bit clock on the other
    always_comb begin
        aso_cfg_t c;
        logic [15:0] lw;
        logic [4:0] nb;
        c = load ? r.hold.cfg : r.cur;
        lw = '0;
        nb = nBits(c);
        n = r;
        n.reqS1 = w.req;
        n.reqS2 = r.reqS1;
        if (r.reqS2 != r.seen) begin
            n.hold = w.word;
            n.seen = r.reqS2;
        end
        n.half = !r.half;
        if (!r.half) begin
            for (int l = 0; l < 8; l++) begin
                lw = load ? laneBits(c, r.hold.data[l/2], (l % 2) == 1) : r.sh[l];
                n.dout[l] = lw[15];
                n.sh[l] = lw << 1;
            end
            if (load) begin
                n.cur = r.hold.cfg;
            end
            n.frame = (r.cnt < ((nb + 5'd1) >> 1));
            n.cnt = (r.cnt + 5'd1 >= nb) ? 5'd0 : r.cnt + 5'd1;
        end else begin
            n.bclk = !r.bclk;
        end
    end

    always_ff @(posedge linkClk or negedge linkRstN) begin
        if (!linkRstN) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    edge_mid_bit_a: assert property (@(posedge linkClk) disable iff (!linkRstN)
        $changed(bitClockOut) |-> $stable(serData)) else $error("clock edge on data edge");
    bit_clock_rate_a: assert property (@(posedge linkClk) disable iff (!linkRstN)
        $changed(bitClockOut) |=> $stable(bitClockOut) ##1 $changed(bitClockOut))
        else $error("bit clock not one bit per two cycles");
    sync_run_a: assert property (@(posedge linkClk) disable iff (!linkRstN)
        load && r.hold.cfg.sync && r.hold.cfg.twoWire && !r.hold.cfg.ser16
        && !r.hold.cfg.lsbFirst |=> serData[0] [*8] ##1 !serData[0] [*6])
        else $error("frame pattern wrong on wire");
    deskew_alt_a: assert property (@(posedge linkClk) disable iff (!linkRstN)
        load && r.hold.cfg.deskew |=> serData[1] [*2] ##1 !serData[1] [*2] ##1 serData[1] [*2])
        else $error("deskew not alternating");
endmodule : aso_ser
`default_nettype wire

// [hw/aso_top.sv]
`include "aso_map.svh"
`default_nettype none
module aso_top
    import aso_pkg::*;
(
    // system clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // link clock
    input wire logic linkClk,
    // conversion results
    input wire logic sampleValid,
    input wire logic [3:0][13:0] sampleData,
    output logic sampleReady,
    // pattern and interface setup
    input wire aso_pat_t patSel,
    input wire logic [6:0] customHigh,
    input wire logic [6:0] customLow,
    input wire logic twoWire,
    input wire logic ser16,
    input wire logic bitWise,
    input wire logic lsbFirst,
    input wire logic pdClkGeTs,
    // termination and drive setup
    input wire logic [4:0] termClkSel,
    input wire logic [4:0] termDataSel,
    input wire logic currentDoubleIn,
    // serial link
    output logic [7:0] serData,
    output logic frameClkOut,
    output logic bitClockOut,
    // buffer and latency status
    output logic [4:0] termClkEn,
    output logic [4:0] termDataEn,
    output logic [15:0] termClkG,
    output logic [15:0] termDataG,
    output logic outputCurrentDoubling,
    output logic [4:0] latencyCycles
);
    typedef struct packed {
        logic [14:0][3:0][13:0] line;
        logic tgl;
        aso_hs_t hs;
        logic reqT;
        logic ackS1;
        logic ackS2;
        aso_word_t word;
        logic [4:0] termClk;
        logic [4:0] termData;
        logic [15:0] gClk;
        logic [15:0] gData;
        logic cdbl;
        logic [4:0] lat;
    } aso_top_st_t;
    aso_top_st_t r, n;
    logic [1:0] rstPipe_r;
    logic [1:0] linkRstPipe_r;
    logic rstN, linkRstN;
    logic push;
    logic [4:0] tapIdx;
    logic [3:0][13:0] tap;
    aso_word_t fifoIn, fifoOut;
    logic fifoInReady, fifoOutValid, fifoOutReady;
    // word carrier to the link side, declared before the handshake logic reads it
    aso_word_if wif ();

    // whole samples of delay from capture to the serializer
    function automatic logic [4:0] latFor(logic tw, logic s16, logic pd);
        if (!tw) begin
            latFor = `ASO_PIPE_LAT + `ASO_SER_LAT_1W;
        end else if (!s16) begin
            latFor = `ASO_PIPE_LAT + (pd ? `ASO_SER_LAT_LONG : `ASO_SER_LAT_SHORT);
        end else begin
            latFor = `ASO_PIPE_LAT + `ASO_SER_LAT_OTHER;
        end
    endfunction : latFor

    // parallel termination as conductance in microsiemens
    function automatic logic [15:0] gSum(logic [4:0] sel);
        gSum = (sel[0] ? `ASO_G166 : 16'h0000) + (sel[1] ? `ASO_G200 : 16'h0000)
             + (sel[2] ? `ASO_G250 : 16'h0000) + (sel[3] ? `ASO_G333 : 16'h0000)
             + (sel[4] ? `ASO_G500 : 16'h0000);
    endfunction : gSum

    // one channel's word after pattern substitution
    function automatic logic [13:0] patData(aso_pat_t p, logic t, logic [13:0] d,
                                            logic [13:0] cust);
        case (p)
            ASO_PAT_NONE: patData = d;
            ASO_PAT_ZEROS: patData = 14'h0000;
            ASO_PAT_ONES: patData = `ASO_ALL_ONES;
            ASO_PAT_TOGGLE: patData = t ? `ASO_TOGGLE_B : `ASO_TOGGLE_A;
            ASO_PAT_CUSTOM: patData = cust;
            default: patData = 14'h0000;
        endcase
    endfunction : patData

    // reset release, system side
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_r <= 2'b00;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end

    // reset release, link side
    always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
            linkRstPipe_r <= 2'b00;
        end else begin
            linkRstPipe_r <= {linkRstPipe_r[0], 1'b1};
        end
    end

    assign rstN = rstPipe_r[1];
    assign linkRstN = linkRstPipe_r[1];

    // pattern choice rides with each word so a change never splits a sample
    always_comb begin
        tapIdx = latFor(twoWire, ser16, pdClkGeTs) - 5'd1;
        tap = r.line[tapIdx];
        fifoIn = '0;
        fifoIn.cfg.twoWire = twoWire;
        fifoIn.cfg.ser16 = ser16;
        fifoIn.cfg.bitWise = bitWise;
        fifoIn.cfg.lsbFirst = lsbFirst;
        fifoIn.cfg.sync = (patSel == ASO_PAT_SYNC);
        fifoIn.cfg.deskew = (patSel == ASO_PAT_DESKEW);
        for (int ch = 0; ch < 4; ch++) begin
            fifoIn.data[ch] = patData(patSel, r.tgl, tap[ch], {customHigh, customLow});
        end
    end

    assign push = sampleValid && fifoInReady;
    assign sampleReady = fifoInReady;
    assign fifoOutReady = (r.hs == ASO_HS_IDLE);

    // sample buffer; a slow link stalls the sample source
    aso_fifo #(
        .W($bits(aso_word_t)),
        .D(`ASO_FIFO_DEPTH)
    ) uFifo (
        .clk(clk),
        .rstN(rstN),
        .inValid(sampleValid),
        .inData(fifoIn),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOut),
        .outReady(fifoOutReady)
    );

    // delay line, toggle phase, word handshake and setup registers
    always_comb begin
        n = r;
        if (push) begin
            n.line = {r.line[13:0], sampleData};
            n.tgl = !r.tgl;
        end
        n.ackS1 = wif.ack;
        n.ackS2 = r.ackS1;
        case (r.hs)
            ASO_HS_IDLE: begin
                if (fifoOutValid) begin
                    n.word = fifoOut;
                    n.reqT = !r.reqT;
                    n.hs = ASO_HS_BUSY;
                end
            end
            ASO_HS_BUSY: begin
                if (r.ackS2 == r.reqT) begin
                    n.hs = ASO_HS_IDLE;
                end
            end
            default: n.hs = ASO_HS_IDLE;
        endcase
        n.termClk = termClkSel;
        n.termData = termDataSel;
        n.gClk = gSum(termClkSel);
        n.gData = gSum(termDataSel);
        n.cdbl = currentDoubleIn;
        n.lat = latFor(twoWire, ser16, pdClkGeTs);
    end

    // word held steady until the link side has echoed the toggle
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            r <= '0;
            r.hs <= ASO_HS_IDLE;
        end else begin
            r <= n;
        end
    end

    assign wif.word = r.word;
    assign wif.req = r.reqT;

    aso_ser uSer (
        .linkClk(linkClk),
        .linkRstN(linkRstN),
        .w(wif.snk),
        .serData(serData),
        .frameClkOut(frameClkOut),
        .bitClockOut(bitClockOut)
    );

    assign termClkEn = r.termClk;
    assign termDataEn = r.termData;
    assign termClkG = r.gClk;
    assign termDataG = r.gData;
    assign outputCurrentDoubling = r.cdbl;
    // counted in samples; the analog pipeline itself is outside this block
    assign latencyCycles = r.lat;

    pipe_delay_a: assert property (@(posedge clk) disable iff (!rstN)
        push && patSel == ASO_PAT_NONE |=> r.line[r.lat] == $past(fifoIn.data))
        else $error("sample not delayed by latency");
    one_wire_lat_a: assert property (@(posedge clk) disable iff (!rstN)
        !twoWire |=> latencyCycles == 5'd12) else $error("single-wire latency wrong");
    two_wire_lat_a: assert property (@(posedge clk) disable iff (!rstN)
        twoWire && !ser16 |=> latencyCycles == ($past(pdClkGeTs) ? 5'd14 : 5'd13))
        else $error("two-wire latency wrong");
    toggle_flip_a: assert property (@(posedge clk) disable iff (!rstN)
        push && patSel == ASO_PAT_TOGGLE |-> fifoIn.data[0] == (r.tgl ? 14'h1555 : 14'h2AAA)
        ##1 r.tgl != $past(r.tgl)) else $error("toggle word wrong");
    all_chan_a: assert property (@(posedge clk) disable iff (!rstN)
        push && patSel != ASO_PAT_NONE |-> fifoIn.data[0] == fifoIn.data[1]
        && fifoIn.data[1] == fifoIn.data[2] && fifoIn.data[2] == fifoIn.data[3])
        else $error("channels differ under pattern");
    fixed_words_a: assert property (@(posedge clk) disable iff (!rstN)
        push |-> (patSel != ASO_PAT_ZEROS || fifoIn.data[3] == 14'h0000)
        && (patSel != ASO_PAT_ONES || fifoIn.data[3] == 14'h3FFF)
        && (patSel != ASO_PAT_CUSTOM || fifoIn.data[3] == {customHigh, customLow}))
        else $error("fixed pattern word wrong");
    term_full_a: assert property (@(posedge clk) disable iff (!rstN)
        termDataSel == 5'h1F |=> termDataG == 16'h4E3B) else $error("parallel sum wrong");
    term_split_a: assert property (@(posedge clk) disable iff (!rstN)
        $stable(termClkSel) && $changed(termDataSel) |=> $stable(termClkEn)
        && termDataEn == $past(termDataSel)) else $error("termination settings coupled");
    word_hold_a: assert property (@(posedge clk) disable iff (!rstN)
        r.hs == ASO_HS_BUSY |=> $stable(r.word)) else $error("word moved during crossing");
endmodule : aso_top
`default_nettype wire

// [verif/aso_rx_model.sv]
`default_nettype none
module aso_rx_model (
    // serial link from the device
    input wire logic linkClk,
    input wire logic [7:0] serData,
    input wire logic frameClkOut,
    input wire logic bitClockOut,
    // last complete word per lane, first bit highest
    output logic [7:0][15:0] lastWord,
    output logic [4:0] lastBits,
    output logic [15:0] wordCnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic bcoPrev = 1'b0;
    logic frmPrev = 1'b1;
    logic [7:0][15:0] sh = '0;
    logic [4:0] cnt = '0;
    logic [7:0][15:0] lastW = '0;
    logic [4:0] lastB = '0;
    logic [15:0] wc = '0;

    assign lastWord = lastW;
    assign lastBits = lastB;
    assign wordCnt = wc;

    // any bit clock change marks mid bit, so data is stable here
    always @(posedge linkClk) begin
        if (bitClockOut != bcoPrev) begin
            // word boundary taken from the frame clock's rising edge
            if (frameClkOut && !frmPrev) begin
                lastW <= sh;
                lastB <= cnt;
                wc <= wc + 16'h0001;
                cnt <= 5'h01;
                for (int i = 0; i < 8; i++) sh[i] <= {15'h0000, serData[i]};
            end else begin
                cnt <= cnt + 5'h01;
                for (int i = 0; i < 8; i++) sh[i] <= {sh[i][14:0], serData[i]};
            end
            frmPrev <= frameClkOut;
        end
        bcoPrev <= bitClockOut;
    end
endmodule : aso_rx_model
`default_nettype wire

// [verif/tb_adc_serial_output_test_patterns.sv]
`default_nettype none
module tb_adc_serial_output_test_patterns;
    import aso_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic arst_n = 1'b0;
    logic sampleValid = 1'b0;
    logic [3:0][13:0] sampleData = '0;
    logic sampleReady;
    aso_pat_t patSel = ASO_PAT_NONE;
    logic [6:0] customHigh = '0;
    logic [6:0] customLow = '0;
    logic twoWire = 1'b0;
    logic ser16 = 1'b0;
    logic bitWise = 1'b0;
    logic lsbFirst = 1'b0;
    logic pdClkGeTs = 1'b0;
    logic [4:0] termClkSel = '0;
    logic [4:0] termDataSel = '0;
    logic currentDoubleIn = 1'b0;
    logic [7:0] serData;
    logic frameClkOut;
    logic bitClockOut;
    logic [4:0] termClkEn;
    logic [4:0] termDataEn;
    logic [15:0] termClkG;
    logic [15:0] termDataG;
    logic outputCurrentDoubling;
    logic [4:0] latencyCycles;
    logic [7:0][15:0] lastWord;
    logic [4:0] lastBits;
    logic [15:0] wordCnt;
    int fails = 0;
    int samplesChecked = 0;

    aso_top dut_u (.clk(clk), .arst_n(arst_n), .linkClk(linkClk), .sampleValid(sampleValid),
        .sampleData(sampleData), .sampleReady(sampleReady), .patSel(patSel),
        .customHigh(customHigh), .customLow(customLow), .twoWire(twoWire), .ser16(ser16),
        .bitWise(bitWise), .lsbFirst(lsbFirst), .pdClkGeTs(pdClkGeTs),
        .termClkSel(termClkSel), .termDataSel(termDataSel), .currentDoubleIn(currentDoubleIn),
        .serData(serData), .frameClkOut(frameClkOut), .bitClockOut(bitClockOut),
        .termClkEn(termClkEn), .termDataEn(termDataEn), .termClkG(termClkG),
        .termDataG(termDataG), .outputCurrentDoubling(outputCurrentDoubling),
        .latencyCycles(latencyCycles));

    aso_rx_model rx_u (.linkClk(linkClk), .serData(serData), .frameClkOut(frameClkOut),
        .bitClockOut(bitClockOut), .lastWord(lastWord), .lastBits(lastBits),
        .wordCnt(wordCnt));

    // 50 MHz system clock, 6 ns link clock with an odd phase offset
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #1.3;
        forever #3 linkClk = ~linkClk;
    end

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : giveVerdict

    // bits of one wire in send order, first bit highest; per-wire patterns built here
    function automatic logic [15:0] expWire(int pat, logic [13:0] w, int wi);
        int n;
        logic [15:0] w16;
        logic [15:0] v;
        logic [15:0] r;
        n = twoWire ? (ser16 ? 8 : 7) : (ser16 ? 16 : 14);
        w16 = {2'b00, w};
        v = 16'h0000;
        r = 16'h0000;
        for (int i = 0; i < n; i++) begin
            if (pat == 5) v[n-1-i] = (i < (n + 1) / 2);
            else if (pat == 6) v[n-1-i] = ~i[0];
            else if (!twoWire) v[i] = w16[i];
            else if (bitWise) v[i] = w16[2*i+wi];
            else v[i] = w16[n*wi+i];
        end
        for (int i = 0; i < n; i++) r[i] = (lsbFirst && pat != 6) ? v[n-1-i] : v[i];
        return r;
    endfunction : expWire

    // one pattern under one random setup, then the settled word on every lane in two-wire mode, even lanes only in one-wire mode
    task automatic runCase(int pat);
        logic [3:0][13:0] d;
        logic [13:0] w;
        logic [15:0] e;
        logic [15:0] g;
        int k;
        int guard;
        int base;
        int gv[5] = '{6024, 5000, 4000, 3003, 2000};
        for (int c = 0; c < 4; c++) d[c] = 14'($urandom);
        @(posedge clk);
        sampleData <= d;
        sampleValid <= 1'b1;
        patSel <= aso_pat_t'(pat[2:0]);
        {customHigh, customLow} <= 14'($urandom);
        {twoWire, ser16, bitWise, lsbFirst, pdClkGeTs} <= 5'($urandom);
        {termClkSel, termDataSel, currentDoubleIn} <= 11'($urandom);
        k = 0;
        guard = 0;
        // full buffer holds the source back; it must keep offering
        while (k < 20 && guard < 5000) begin
            @(posedge clk);
            if (sampleReady === 1'b1) k++;
            guard++;
        end
        sampleValid <= 1'b0;
        base = wordCnt;
        guard = 0;
        while (int'(wordCnt) - base < 36 && guard < 3000) begin
            @(posedge clk);
            guard++;
        end
        check("done", 16'(k == 20 && guard < 3000), 16'h0001);
        check("bits", 16'(lastBits), 16'(twoWire ? (ser16 ? 8 : 7) : (ser16 ? 16 : 14)));
        for (int c = 0; c < 4; c++) begin
            case (pat)
                0: w = d[c];
                1: w = 14'h0000;
                2: w = 14'h3FFF;
                // every case pushes an even count, so the last word is the second code
                3: w = 14'h1555;
                default: w = {customHigh, customLow};
            endcase
            for (int wi = 0; wi < (twoWire ? 2 : 1); wi++) begin
                e = expWire(pat, w, wi);
                check("lane", lastWord[2*c+wi], e);
            end
        end
        check("lat", 16'(latencyCycles), 16'(12 + ((twoWire && !ser16) ? (pdClkGeTs ? 2 : 1)
            : 0)));
        check("tcEn", 16'(termClkEn), 16'(termClkSel));
        check("tdEn", 16'(termDataEn), 16'(termDataSel));
        check("dbl", 16'(outputCurrentDoubling), 16'(currentDoubleIn));
        g = 16'h0000;
        for (int i = 0; i < 5; i++) g += termClkSel[i] ? 16'(gv[i]) : 16'h0000;
        check("tcG", termClkG, g);
        g = 16'h0000;
        for (int i = 0; i < 5; i++) g += termDataSel[i] ? 16'(gv[i]) : 16'h0000;
        check("tdG", termDataG, g);
    endtask : runCase

    // hang guard, well beyond the expected run of about 7.5k cycles
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        giveVerdict();
    end

    initial begin
        void'($urandom(32'hB922));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int rep = 0; rep < 4; rep++) begin
            for (int pat = 0; pat < 7; pat++) runCase(pat);
        end
        giveVerdict();
    end
endmodule : tb_adc_serial_output_test_patterns
`default_nettype wire
